// *** design/rbx_params.svh ***
// Constants for the relative branch and bit set executor
`ifndef RBX_PARAMS_SVH
`define RBX_PARAMS_SVH
`define RBX_OP_BNCC 8'he3
`define RBX_OP_BNNG 8'he7
`define RBX_OP_BNOF 8'he5
`define RBX_OP_BNZR 8'he1
`define RBX_OP_BALW 5'h1a
`define RBX_OP_BSET 4'h8
`define RBX_IDX_LIMIT 8'h5f
`define RBX_ACC_SPLIT 8'h60
`define RBX_ACC_HI_BANK 4'hf
`define RBX_ACC_LO_BANK 4'h0
`define RBX_PC_RESET 21'h000000
`define RBX_PC_STEP 21'h000002
`endif

// *** design/rbx_pkg.sv ***
// Types for the relative branch and bit set executor
package rbx_pkg;
    typedef struct packed {
        logic neg;
        logic ovf;
        logic zero;
        logic carry;
    } rbx_flags_t;
    typedef struct packed {
        logic req;
        logic we;
        logic [11:0] addr;
        logic [7:0] wdata;
    } rbx_mem_t;
    typedef enum logic [3:0] {
        RBX_Q1 = 4'h1,
        RBX_Q2 = 4'h2,
        RBX_Q3 = 4'h4,
        RBX_Q4 = 4'h8
    } rbx_phase_t;
endpackage

// *** design/rbx_phase_gen.sv ***
// Four phase sequencer of one instruction cycle
`timescale 1ns/1ns
`default_nettype none
module rbx_phase_gen
    import rbx_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    output rbx_phase_t phase
);
    rbx_phase_t phase_ff;

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            phase_ff <= RBX_Q1;
        else
        begin
            case (phase_ff)
                RBX_Q1: phase_ff <= RBX_Q2;
                RBX_Q2: phase_ff <= RBX_Q3;
                RBX_Q3: phase_ff <= RBX_Q4;
                RBX_Q4: phase_ff <= RBX_Q1;
                default: phase_ff <= RBX_Q1;
            endcase
        end
    end

    assign phase = phase_ff;

    phase_order_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        phase_ff == RBX_Q4 |=> phase_ff == RBX_Q1)
        else $error("phase did not wrap to Q1");
endmodule
`default_nettype wire

// *** design/rbx_exec.sv ***
// Executor for not-set relative branches, unconditional branch and bit set
`timescale 1ns/1ns
`default_nettype none
`include "rbx_params.svh"
// Overview of operation
// RULE1 - Opcode e3 with 8-bit offset branches only when carry is zero.
// RULE2 - Opcode e7 with 8-bit offset branches only when negative is zero.
// RULE3 - Opcode e5 with 8-bit offset branches only when overflow is zero.
// RULE4 - Opcode e1 with 8-bit offset branches only when zero flag is zero.
// RULE5 - Taken branch target is incremented counter plus twice signed offset.
// RULE6 - Conditional branch: one word, one cycle untaken, two cycles taken.
// RULE7 - Taken: first cycle writes counter in Q4, second cycle idles.
// RULE8 - Untaken: no write in Q4, counter just advances.
// RULE9 - Relative branches never change any status flag.
// RULE10 - Top five bits 11010 give unconditional branch with 11-bit offset.
// RULE11 - Unconditional branch always takes two cycles, second idles.
// RULE12 - Opcode 1000 sets selected bit, others and flags untouched.
// RULE13 - Access flag zero addresses the access bank.
// RULE14 - Access flag one uses bank select register for the bank.
// RULE15 - Extended set, access zero, address up to 5f uses indexed offset.
// RULE16 - Bit set reads in Q2, modifies in Q3, writes in Q4.
module rbx_exec
    import rbx_pkg::*;
#(
    parameter int PC_W = 21
)
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [15:0] instr,
    input wire logic instr_valid,
    input wire rbx_flags_t flags_in,
    input wire logic [3:0] bank_select_reg,
    input wire logic ext_set_en,
    input wire logic [11:0] index_base,
    input wire logic [7:0] mem_rdata,
    output rbx_mem_t mem_ctl,
    output rbx_flags_t flags_out,
    output logic [PC_W-1:0] pc_out,
    output logic pc_write,
    output logic flush_cycle,
    output rbx_phase_t phase_out
);
    rbx_phase_t phase;
    logic [PC_W-1:0] pc_ff;
    logic [15:0] ir_ff;
    logic [7:0] data_ff;
    logic [11:0] addr_ff;
    logic take_ff;
    logic bset_ff;
    logic flush_ff;
    logic pc_write_ff;
    rbx_mem_t mem_ff;
    logic dec_take;
    logic dec_bset;
    logic [PC_W-1:0] offs_ext;

    rbx_phase_gen u_phase (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .phase(phase)
    );

    function automatic logic [11:0] bset_addr(input logic [7:0] f, input logic a,
                                              input logic [3:0] bank, input logic ext,
                                              input logic [11:0] base);
        logic [11:0] r;
        r = {bank, f}; // RULE14
        if (!a)
        begin
            if (ext && f <= `RBX_IDX_LIMIT)
                r = base + {4'h0, f}; // RULE15
            else if (f < `RBX_ACC_SPLIT)
                r = {`RBX_ACC_LO_BANK, f}; // RULE13
            else
                r = {`RBX_ACC_HI_BANK, f}; // RULE13
        end
        return r;
    endfunction

    // Decode of taken branches; flags only sampled, never written
    always_comb
    begin
        dec_take = 1'b0;
        if (instr[15:8] == `RBX_OP_BNCC)
            dec_take = !flags_in.carry; // RULE1
        else if (instr[15:8] == `RBX_OP_BNNG)
            dec_take = !flags_in.neg; // RULE2
        else if (instr[15:8] == `RBX_OP_BNOF)
            dec_take = !flags_in.ovf; // RULE3
        else if (instr[15:8] == `RBX_OP_BNZR)
            dec_take = !flags_in.zero; // RULE4
        else if (instr[15:11] == `RBX_OP_BALW)
            dec_take = 1'b1; // RULE10 RULE11
        dec_bset = instr[15:12] == `RBX_OP_BSET;
    end

    // Offset from the latched word; the live bus may hold the next fetch by Q4
    always_comb
    begin
        offs_ext = {{(PC_W-8){ir_ff[7]}}, ir_ff[7:0]};
        if (ir_ff[15:11] == `RBX_OP_BALW)
            offs_ext = {{(PC_W-11){ir_ff[10]}}, ir_ff[10:0]}; // RULE10
    end

    // Q1 decode and latch
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            ir_ff <= 16'h0000;
            take_ff <= 1'b0;
            bset_ff <= 1'b0;
            addr_ff <= 12'h000;
        end
        else if (phase == RBX_Q1)
        begin
            ir_ff <= instr;
            take_ff <= instr_valid && !flush_ff && dec_take;
            bset_ff <= instr_valid && !flush_ff && dec_bset;
            addr_ff <= bset_addr(instr[7:0], instr[8], bank_select_reg,
                                 ext_set_en, index_base); // RULE14
        end
    end

    // Program counter: advance every cycle, or branch target in Q4
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            pc_ff <= `RBX_PC_RESET;
        else if (phase == RBX_Q4)
        begin
            if (take_ff)
                pc_ff <= pc_ff + `RBX_PC_STEP + {offs_ext[PC_W-2:0], 1'b0}; // RULE5 RULE7
            else
                pc_ff <= pc_ff + `RBX_PC_STEP; // RULE8
        end
    end

    // Idle second cycle after a taken branch; write strobe stands one phase
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            flush_ff <= 1'b0;
            pc_write_ff <= 1'b0;
        end
        else if (phase == RBX_Q4)
        begin
            flush_ff <= take_ff; // RULE6 RULE11
            pc_write_ff <= take_ff;
        end
        else if (phase == RBX_Q1)
            pc_write_ff <= 1'b0;
    end

    // Bit set read, modify, write
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            mem_ff <= '0;
            data_ff <= 8'h00;
        end
        else
        begin
            mem_ff.req <= 1'b0;
            mem_ff.we <= 1'b0;
            case (phase)
                RBX_Q1:
                begin
                    mem_ff.req <= dec_bset && instr_valid && !flush_ff; // RULE16
                    mem_ff.addr <= bset_addr(instr[7:0], instr[8], bank_select_reg,
                                             ext_set_en, index_base);
                end
                RBX_Q2: data_ff <= mem_rdata; // RULE16
                RBX_Q3: data_ff <= data_ff | (8'h01 << ir_ff[11:9]); // RULE12
                RBX_Q4:
                begin
                    mem_ff.req <= 1'b0;
                end
                default: data_ff <= data_ff;
            endcase
            if (phase == RBX_Q3 && bset_ff)
            begin
                mem_ff.req <= 1'b1;
                mem_ff.we <= 1'b1; // RULE16
                mem_ff.addr <= addr_ff;
                mem_ff.wdata <= data_ff | (8'h01 << ir_ff[11:9]);
            end
        end
    end

    assign mem_ctl = mem_ff;
    assign flags_out = flags_in; // RULE9 RULE12
    assign pc_out = pc_ff;
    assign pc_write = pc_write_ff;
    assign flush_cycle = flush_ff;
    assign phase_out = phase;

    property taken_target_p;
        @(posedge core_clk) disable iff (sys_rst)
        (phase == RBX_Q4 && take_ff && ir_ff[15:11] == `RBX_OP_BALW)
        |=> pc_ff == $past(pc_ff) + `RBX_PC_STEP
            + {{(PC_W-12){ir_ff[10]}}, ir_ff[10:0], 1'b0};
    endproperty
    branch_target_a: assert property (taken_target_p) // RULE5
        else $error("branch target wrong");
    cond_taken_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (phase == RBX_Q1 && instr_valid && !flush_ff && instr[15:8] == `RBX_OP_BNCC
         && !flags_in.carry) |=> take_ff) // RULE1
        else $error("carry clear branch not taken");
    neg_taken_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (phase == RBX_Q1 && instr[15:8] == `RBX_OP_BNNG && flags_in.neg) |=> !take_ff) // RULE2
        else $error("negative clear branch taken wrongly");
    ovf_taken_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (phase == RBX_Q1 && instr[15:8] == `RBX_OP_BNOF && flags_in.ovf) |=> !take_ff) // RULE3
        else $error("overflow clear branch taken wrongly");
    zero_taken_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (phase == RBX_Q1 && instr[15:8] == `RBX_OP_BNZR && flags_in.zero) |=> !take_ff) // RULE4
        else $error("zero clear branch taken wrongly");
    flush_cycle_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (phase == RBX_Q4 && take_ff) |=> flush_ff [*4]) // RULE6
        else $error("taken branch lacks idle cycle");
    untaken_step_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (phase == RBX_Q4 && !take_ff) |=> pc_ff == $past(pc_ff) + `RBX_PC_STEP) // RULE8
        else $error("counter did not advance");
    flush_quiet_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (phase == RBX_Q1 && flush_ff) |=> !take_ff && !bset_ff) // RULE7
        else $error("idle cycle did work");
    bset_write_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (phase == RBX_Q3 && bset_ff) |=> mem_ff.we && mem_ff.wdata[ir_ff[11:9]]) // RULE12
        else $error("bit set write wrong");
    cover_taken_c: cover property (@(posedge core_clk) phase == RBX_Q4 && take_ff);
    cover_untaken_c: cover property (@(posedge core_clk) phase == RBX_Q4 && !take_ff);
    cover_bset_c: cover property (@(posedge core_clk) mem_ff.we);
endmodule
`default_nettype wire

// *** tb/rbx_data_mem.sv ***
// Behavioural data memory on the far side of the executor
`timescale 1ns/1ns
`default_nettype none
module rbx_data_mem
    import rbx_pkg::*;
(
    input wire logic core_clk,
    input wire rbx_mem_t mem_ctl,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem [4096];
    logic [7:0] last_ff = 8'h00;
    // Idle bus shows inverted last value so stale data never passes
    assign mem_rdata = (mem_ctl.req && !mem_ctl.we) ? mem[mem_ctl.addr] : ~last_ff;
    always @(posedge core_clk)
    begin
        last_ff <= mem_rdata;
        if (mem_ctl.req && mem_ctl.we)
            mem[mem_ctl.addr] <= mem_ctl.wdata;
    end
endmodule
`default_nettype wire

// *** tb/relative_branch_bit_set_exec_tb.sv ***
// Self-checking bench for the branch and bit set executor
`timescale 1ns/1ns
`default_nettype none
`include "rbx_params.svh"
module relative_branch_bit_set_exec_tb
    import rbx_pkg::*;
;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [15:0] instr = 16'h0000;
    logic instr_valid = 1'b0;
    rbx_flags_t flags_in = 4'h0;
    logic [3:0] bank_select_reg = 4'h0;
    logic ext_set_en = 1'b0;
    logic [11:0] index_base = 12'h000;
    logic [7:0] mem_rdata;
    rbx_mem_t mem_ctl;
    rbx_flags_t flags_out;
    logic [20:0] pc_out;
    logic pc_write;
    logic flush_cycle;
    rbx_phase_t phase_out;
    logic [7:0] shadow [4096];
    logic [7:0] opc [4] = '{`RBX_OP_BNZR, `RBX_OP_BNCC, `RBX_OP_BNOF, `RBX_OP_BNNG};
    int sel [4] = '{1, 0, 2, 3};
    int fails = 0;
    int n_compared = 0;
    int cycles = 0;
    rbx_exec #(.PC_W(21)) u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .instr(instr),
        .instr_valid(instr_valid), .flags_in(flags_in), .bank_select_reg(bank_select_reg),
        .ext_set_en(ext_set_en), .index_base(index_base), .mem_rdata(mem_rdata),
        .mem_ctl(mem_ctl), .flags_out(flags_out), .pc_out(pc_out), .pc_write(pc_write),
        .flush_cycle(flush_cycle), .phase_out(phase_out));
    rbx_data_mem u_mem (.core_clk(core_clk), .mem_ctl(mem_ctl), .mem_rdata(mem_rdata));
    always #20 core_clk = ~core_clk;
    task automatic end_sim();
        if (fails == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Run is short; a hang long past it means a stuck sequencer
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fails++;
            end_sim();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick();
        @(posedge core_clk);
        #1;
    endtask
    task automatic issue(input logic [15:0] w, input rbx_flags_t f);
        while (phase_out !== RBX_Q1)
            tick();
        instr = w;
        instr_valid = 1'b1;
        flags_in = f;
    endtask
    task automatic branch(input logic [15:0] w, input rbx_flags_t f, input logic tk,
                          input logic [20:0] n);
        logic [20:0] p0;
        logic [20:0] e;
        issue(w, f);
        p0 = pc_out;
        e = tk ? p0 + 21'h000002 + (n << 1) : p0 + 21'h000002;
        repeat (4) tick();
        // Bit set offered in the idle cycle must be ignored
        instr = 16'h8f00;
        instr_valid = tk;
        chk(pc_out, e);
        chk(flags_out, f);
        for (int i = 0; i < 4; i++)
        begin
            chk({flush_cycle, pc_write, mem_ctl.req}, {tk, tk && i == 0, 1'b0});
            tick();
        end
    endtask
    task automatic bitset(input logic [2:0] b, input logic a, input logic [7:0] f,
                          input rbx_flags_t fl);
        logic [11:0] ad;
        logic [7:0] wd;
        ad = a ? {bank_select_reg, f} : (ext_set_en && f <= 8'h5f) ? index_base + {4'h0, f}
             : {(f < 8'h60) ? 4'h0 : 4'hf, f};
        wd = shadow[ad] | (8'h01 << b);
        shadow[ad] = wd;
        issue({4'h8, b, a, f}, fl);
        tick();
        chk({mem_ctl.req, mem_ctl.we, mem_ctl.addr}, {2'b10, ad});
        repeat (2) tick();
        chk(mem_ctl, {2'b11, ad, wd});
        chk(phase_out, RBX_Q4);
        chk(flags_out, fl);
        tick();
    endtask
    initial
    begin
        logic [7:0] o;
        logic [10:0] lo;
        rbx_flags_t fl;
        void'($urandom(22258));
        for (int i = 0; i < 4096; i++)
        begin
            u_mem.mem[i] = $urandom;
            shadow[i] = u_mem.mem[i];
        end
        repeat (6) @(posedge core_clk);
        #1;
        sys_rst = 1'b0;
        for (int i = 0; i < 40; i++)
        begin
            fl = (i < 4) ? 4'hf : (i < 8) ? 4'h0 : 4'($urandom);
            o = (i == 8) ? 8'h80 : (i == 9) ? 8'h7f : 8'($urandom);
            branch({opc[i % 4], o}, fl, !fl[sel[i % 4]], {{13{o[7]}}, o});
        end
        for (int i = 0; i < 6; i++)
        begin
            lo = (i == 0) ? 11'h400 : (i == 1) ? 11'h3ff : 11'($urandom);
            branch({`RBX_OP_BALW, lo}, 4'($urandom), 1'b1, {{10{lo[10]}}, lo});
        end
        for (int i = 0; i < 24; i++)
        begin
            bank_select_reg = $urandom;
            ext_set_en = (i < 8) ? 1'b1 : 1'($urandom);
            index_base = $urandom;
            bitset($urandom, (i < 8) ? 1'b0 : 1'($urandom), (i < 4) ? 8'h5e + 8'(i) : 8'($urandom),
                   4'($urandom));
        end
        instr_valid = 1'b0;
        end_sim();
    end
endmodule
`default_nettype wire
